// [rtl/uss_clock_select.sv]
// clock-source selection, shift register, counter and pin routing
//
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "uss_regs.svh"

module uss_clock_select (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              link_clk,
  input  wire logic              timer0_match,
  input  wire uss_pkg::uss_pin_t pa_in,
  input  wire uss_pkg::uss_pin_t pb_in,
  output var uss_pkg::uss_pin_t  pa_out,
  output var uss_pkg::uss_pin_t  pa_oe,
  output var uss_pkg::uss_pin_t  pb_out,
  output var uss_pkg::uss_pin_t  pb_oe
);
  import uss_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic       wr_ph_reg;
  logic [2:0] wa_reg;
  logic       addr_ok;
  logic       wr_ctl;
  logic       wr_data;
  logic       wr_sts;
  logic       wr_pin;
  logic       wr_port;
  logic       rd_ph;
  uss_wm_e    wm_reg;
  uss_src_e   cs_reg;
  uss_src_e   cs_next;
  logic       clk_sel_reg;
  logic       sel_next;
  logic       stb_wr;
  logic       tgl_wr;
  logic [7:0] shreg_reg;
  logic [3:0] cnt_reg;
  logic       ovf_reg;
  logic       dout_reg;
  logic       data_out;
  logic       pos_reg;
  logic       sck_port_reg;
  logic       sck_dir_reg;
  logic       out_dir_reg;
  logic       in_dir_reg;
  logic [1:0] pin_raw;
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  logic       sck_prev_reg;
  logic       ext_rise;
  logic       ext_fall;
  logic       samp_pos_reg;
  logic       samp_neg_reg;
  logic       sin_ext;
  logic       shift_en;
  logic       cnt_en;
  logic       shift_bit;
  logic       hold_low;
  uss_pin_t   fn_out;
  uss_pin_t   fn_oe;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] uss_dec(input logic [31:0] a);
    case (a)
      `USS_ADDR_CTL:  uss_dec = `USS_IDX_CTL;
      `USS_ADDR_DATA: uss_dec = `USS_IDX_DATA;
      `USS_ADDR_STS:  uss_dec = `USS_IDX_STS;
      `USS_ADDR_PIN:  uss_dec = `USS_IDX_PIN;
      `USS_ADDR_PORT: uss_dec = `USS_IDX_PORT;
      default:        uss_dec = `USS_IDX_NONE;
    endcase
  endfunction

  // counter step for an external source: toggle strobe or both edges
  function automatic logic uss_ext_cnt(input logic sel, input logic tgl,
                                       input logic edge_any);
    uss_ext_cnt = sel ? tgl : edge_any;
  endfunction

  // ---------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ---------------------------------------------------------------
  assign addr_ok   = hsel & htrans[1] & hready & (hsize == `USS_HSIZE_WORD);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ph_reg <= 1'b0;
      wa_reg    <= `USS_IDX_NONE;
    end
    else if (hready)
    begin
      wr_ph_reg <= addr_ok & hwrite;
      wa_reg    <= addr_ok ? uss_dec(haddr) : `USS_IDX_NONE;
    end
  end

  assign wr_ctl  = wr_ph_reg & (wa_reg == `USS_IDX_CTL);
  assign wr_data = wr_ph_reg & (wa_reg == `USS_IDX_DATA);
  assign wr_sts  = wr_ph_reg & (wa_reg == `USS_IDX_STS);
  assign wr_pin  = wr_ph_reg & (wa_reg == `USS_IDX_PIN);
  assign wr_port = wr_ph_reg & (wa_reg == `USS_IDX_PORT);
  assign rd_ph   = ~wr_ph_reg;

  // read data built from the stored index, so a write just before is seen
  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (rd_ph)
    begin
      case (wa_reg)
        `USS_IDX_CTL:  hrdata = {26'h0, wm_reg, cs_reg, 2'h0};
        `USS_IDX_DATA: hrdata = {24'h0, shreg_reg};
        `USS_IDX_STS:  hrdata = {27'h0, ovf_reg, cnt_reg};
        `USS_IDX_PIN:  hrdata = {31'h0, pos_reg};
        `USS_IDX_PORT: hrdata = {28'h0, in_dir_reg, out_dir_reg,
                                 sck_dir_reg, sck_port_reg};
        default:       hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // control register; toggle is an action, never stored; the strobe bit is kept in clk_sel_reg
  // ---------------------------------------------------------------
  assign cs_next  = wr_ctl ? uss_src_e'(hwdata[`USS_CTL_CS]) : cs_reg;
  assign sel_next = wr_ctl ? hwdata[`USS_CTL_STB] : clk_sel_reg;
  assign stb_wr   = wr_ctl & hwdata[`USS_CTL_STB];
  assign tgl_wr   = wr_ctl & hwdata[`USS_CTL_TGL];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wm_reg      <= WM_OFF;
      cs_reg      <= SRC_NONE;
      clk_sel_reg <= 1'b0;
    end
    else if (wr_ctl)
    begin
      wm_reg      <= uss_wm_e'(hwdata[`USS_CTL_WM]);
      cs_reg      <= cs_next;
      clk_sel_reg <= sel_next;
    end
  end

  // ---------------------------------------------------------------
  // pin routing and input synchronisers
  // ---------------------------------------------------------------
  assign pin_raw = pos_reg
                 ? {pa_in[`USS_PIN_SCK], pa_in[`USS_PIN_IN]}
                 : {pb_in[`USS_PIN_SCK], pb_in[`USS_PIN_IN]};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_meta_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
      sck_prev_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      sck_prev_reg <= pin_sync_reg[1];
    end
  end

  assign ext_rise = pin_sync_reg[1] & ~sck_prev_reg;
  assign ext_fall = ~pin_sync_reg[1] & sck_prev_reg;

  // input sampled on the link clock itself; the synchronised edge arrives
  // about three cycles later, well inside the full period it stays valid
  always_ff @(posedge link_clk or negedge hresetn)
  begin
    if (!hresetn)
      samp_pos_reg <= 1'b0;
    else
      samp_pos_reg <= pin_raw[0];
  end

  always_ff @(negedge link_clk or negedge hresetn)
  begin
    if (!hresetn)
      samp_neg_reg <= 1'b0;
    else
      samp_neg_reg <= pin_raw[0];
  end

  assign sin_ext = cs_reg[0] ? samp_neg_reg : samp_pos_reg;

  // ---------------------------------------------------------------
  // clock source selection; inputs work in every wire mode
  // ---------------------------------------------------------------
  always_comb
  begin
    shift_en  = 1'b0;
    cnt_en    = 1'b0;
    shift_bit = pin_sync_reg[0];
    case (cs_next)
      SRC_NONE:
      begin
        shift_en = stb_wr;
        cnt_en   = stb_wr;
      end
      SRC_TIMER:
      begin
        shift_en = timer0_match;
        cnt_en   = timer0_match;
      end
      SRC_EXT_POS:
      begin
        shift_en  = ext_rise;
        shift_bit = sin_ext;
        cnt_en    = uss_ext_cnt(sel_next, tgl_wr, ext_rise | ext_fall);
      end
      SRC_EXT_NEG:
      begin
        shift_en  = ext_fall;
        shift_bit = sin_ext;
        cnt_en    = uss_ext_cnt(sel_next, tgl_wr, ext_rise | ext_fall);
      end
      default:
      begin
        shift_en = 1'b0;
        cnt_en   = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // shift register, counter and overflow flag
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      shreg_reg <= `USS_RST_BYTE;
    else if (wr_data)
      shreg_reg <= hwdata[7:0];
    else if (shift_en)
      shreg_reg <= {shreg_reg[6:0], shift_bit};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_reg <= `USS_RST_CNT;
    else if (wr_sts)
      cnt_reg <= hwdata[`USS_STS_CNT];
    else if (cnt_en)
      cnt_reg <= cnt_reg + `USS_CNT_ONE;
  end

  // a wrap in the cycle of a clearing write still leaves the flag set
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ovf_reg <= 1'b0;
    else
      ovf_reg <= (cnt_en & (cnt_reg == `USS_CNT_MAX))
               | (ovf_reg & ~(wr_sts & hwdata[`USS_STS_OVF]));
  end

  // ---------------------------------------------------------------
  // data output latch
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dout_reg <= 1'b0;
    else if ((cs_reg == SRC_EXT_POS && ext_fall) ||
             (cs_reg == SRC_EXT_NEG && ext_rise))
      dout_reg <= shreg_reg[7];
  end

  assign data_out = (cs_reg == SRC_EXT_POS || cs_reg == SRC_EXT_NEG)
                  ? dout_reg : shreg_reg[7];

  // ---------------------------------------------------------------
  // pin position and port register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pos_reg <= 1'b0;
    else if (wr_pin)
      pos_reg <= hwdata[`USS_PIN_POS];
  end

  // toggle acts on the port value whatever the direction bit says
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sck_port_reg <= 1'b0;
      sck_dir_reg  <= 1'b0;
      out_dir_reg  <= 1'b0;
      in_dir_reg   <= 1'b0;
    end
    else if (wr_port)
    begin
      sck_port_reg <= hwdata[`USS_PORT_SCK];
      sck_dir_reg  <= hwdata[`USS_PORT_SCKDIR];
      out_dir_reg  <= hwdata[`USS_PORT_OUTDIR];
      in_dir_reg   <= hwdata[`USS_PORT_INDIR];
    end
    else if (tgl_wr)
      sck_port_reg <= ~sck_port_reg;
  end

  // ---------------------------------------------------------------
  // output functions and routing
  // ---------------------------------------------------------------
  assign hold_low = (wm_reg == WM_TWO_HOLD) & ovf_reg;

  always_comb
  begin
    fn_out = 3'h0;
    fn_oe  = 3'h0;
    fn_out[`USS_PIN_OUT] = data_out;
    fn_oe[`USS_PIN_OUT]  = (wm_reg == WM_THREE) & out_dir_reg;
    // open-drain data line only pulls low
    fn_oe[`USS_PIN_IN]   = wm_reg[1] & in_dir_reg & ~data_out;
    if (wm_reg[1])
      fn_oe[`USS_PIN_SCK] = sck_dir_reg & (~sck_port_reg | hold_low);
    else
    begin
      fn_out[`USS_PIN_SCK] = sck_port_reg;
      fn_oe[`USS_PIN_SCK]  = sck_dir_reg;
    end
  end

  assign pa_out = pos_reg ? fn_out : 3'h0;
  assign pa_oe  = pos_reg ? fn_oe : 3'h0;
  assign pb_out = pos_reg ? 3'h0 : fn_out;
  assign pb_oe  = pos_reg ? 3'h0 : fn_oe;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_TIMER_STEP:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (cs_reg == SRC_TIMER && !wr_ctl && !wr_sts && timer0_match)
      |=> cnt_reg == $past(cnt_reg) + `USS_CNT_ONE)
    else $error("timer match did not step the counter");

  AST_EXT_SHIFT:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (cs_reg == SRC_EXT_POS && !wr_ctl && !wr_data && ext_rise)
      |=> shreg_reg == {$past(shreg_reg[6:0]), $past(sin_ext)})
    else $error("rising edge did not shift the register");

  AST_EXT_BOTH:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (cs_reg[1] && !clk_sel_reg && !wr_ctl && !wr_sts && ext_fall)
      |=> cnt_reg == $past(cnt_reg) + `USS_CNT_ONE)
    else $error("falling edge did not step the counter");

  AST_OUT_LATCH:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (cs_reg == SRC_EXT_POS && !wr_ctl && ext_fall)
      |=> dout_reg == $past(shreg_reg[7]) ##1 $stable(dout_reg))
    else $error("output latch missed the opposite edge");

  AST_TRANSPARENT:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (!cs_reg[1]) |-> data_out == shreg_reg[7])
    else $error("output latch not transparent");

  AST_STB_COUNT:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_ctl && hwdata[`USS_CTL_CS] == 2'h0 && hwdata[`USS_CTL_STB])
      |=> cnt_reg == $past(cnt_reg) + `USS_CNT_ONE)
    else $error("strobe did not step the counter");

  AST_STB_SHIFT:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_ctl && hwdata[`USS_CTL_CS] == 2'h0 && hwdata[`USS_CTL_STB])
      |=> shreg_reg == {$past(shreg_reg[6:0]), $past(pin_sync_reg[0])})
    else $error("strobe shifted in the wrong bit");

  AST_CTL_ZERO:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_ph && wa_reg == `USS_IDX_CTL) |-> hrdata[1:0] == 2'h0)
    else $error("strobe or toggle bit read as one");

  AST_TGL_COUNT:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_ctl && hwdata[`USS_CTL_CS_HI] && hwdata[`USS_CTL_STB] &&
       hwdata[`USS_CTL_TGL])
      |=> cnt_reg == $past(cnt_reg) + `USS_CNT_ONE)
    else $error("toggle write did not step the counter");

  AST_TGL_PIN:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_ctl && hwdata[`USS_CTL_TGL]) |=> sck_port_reg != $past(sck_port_reg))
    else $error("toggle write did not invert the clock port");

  AST_ROUTE:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (!pos_reg) |-> (pa_oe == 3'h0 && pb_oe == fn_oe))
    else $error("functions not on port b");

  AST_PIN_RSVD:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_ph && wa_reg == `USS_IDX_PIN) |-> hrdata[31:1] == 31'h0)
    else $error("reserved pin position bits read as one");

  AST_HOLD:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (wm_reg == WM_TWO_HOLD && ovf_reg && sck_dir_reg && !wr_port &&
       !wr_ctl && !wr_sts)
      |=> (fn_oe[`USS_PIN_SCK] && !fn_out[`USS_PIN_SCK]))
    else $error("clock line released while overflow pending");

endmodule // uss_clock_select
`default_nettype wire

// [rtl/uss_regs.svh]
// register map, field positions and reset values of the serial shift unit
`ifndef USS_REGS_SVH
`define USS_REGS_SVH

`define USS_ADDR_CTL    32'h0000_0000
`define USS_ADDR_DATA   32'h0000_0004
`define USS_ADDR_STS    32'h0000_0008
`define USS_ADDR_PIN    32'h0000_000C
`define USS_ADDR_PORT   32'h0000_0010

`define USS_IDX_NONE    3'h0
`define USS_IDX_CTL     3'h1
`define USS_IDX_DATA    3'h2
`define USS_IDX_STS     3'h3
`define USS_IDX_PIN     3'h4
`define USS_IDX_PORT    3'h5

`define USS_HSIZE_WORD  3'h2

`define USS_CTL_WM      5:4
`define USS_CTL_CS      3:2
`define USS_CTL_CS_HI   3
`define USS_CTL_STB     1
`define USS_CTL_TGL     0
`define USS_STS_CNT     3:0
`define USS_STS_OVF     4
`define USS_PORT_SCK    0
`define USS_PORT_SCKDIR 1
`define USS_PORT_OUTDIR 2
`define USS_PORT_INDIR  3
`define USS_PIN_POS     0

`define USS_PIN_IN      0
`define USS_PIN_OUT     1
`define USS_PIN_SCK     2

`define USS_RST_BYTE    8'h00
`define USS_RST_CNT     4'h0
`define USS_CNT_ONE     4'h1
`define USS_CNT_MAX     4'hF

`endif

// [rtl/uss_pkg.sv]
// types shared by the serial shift unit
`default_nettype none
package uss_pkg;

  typedef logic [2:0] uss_pin_t;

  typedef enum logic [1:0] {
    SRC_NONE    = 2'b00,
    SRC_TIMER   = 2'b01,
    SRC_EXT_POS = 2'b10,
    SRC_EXT_NEG = 2'b11
  } uss_src_e;

  typedef enum logic [1:0] {
    WM_OFF      = 2'b00,
    WM_THREE    = 2'b01,
    WM_TWO      = 2'b10,
    WM_TWO_HOLD = 2'b11
  } uss_wm_e;

endpackage
`default_nettype wire

// [dv/uss_serial_partner.sv]
// behavioural external serial master on the clock and data-in pins
`timescale 1ns/1ps
`default_nettype none

module uss_serial_partner (
  input  wire logic       start,
  input  wire logic [4:0] n_edges,
  input  wire logic       sample_fall,
  input  wire logic [7:0] tx_byte,
  output logic            sck,
  output logic            sdi,
  output logic            busy
);
  int done;

  initial
  begin
    sck  = 1'b0;
    sdi  = 1'b0;
    busy = 1'b0;
  end

  // ---------------------------------------------------------------
  // frame engine
  // ---------------------------------------------------------------
  // clock stands still between frames; after the first bit is set at the start, data moves only on the edge
  // that does not sample, and goes stale once its hold has run out
  always @(posedge start)
  begin
    busy = 1'b1;
    done = 0;
    sdi  = tx_byte[7];
    #3;
    repeat (n_edges)
    begin
      #32 sck = ~sck;
      if (sck != sample_fall)
        done++;
      else if (done < 8)
        sdi = tx_byte[7 - done];
    end
    #32 sdi = ~sdi;
    busy = 1'b0;
  end
endmodule // uss_serial_partner
`default_nettype wire

// [dv/serial_shift_clock_select_tb.sv]
// self-checking bench for the serial shift unit clock selection
`timescale 1ns/1ps
`default_nettype none
`include "uss_regs.svh"

module serial_shift_clock_select_tb;
  import uss_pkg::*;

  logic          hclk, hresetn, hsel, hwrite, timer0_match;
  logic [31:0]   haddr, hwdata, hrdata, rdata_q;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  logic          hreadyout, hresp, sck, sdi, busy;
  logic          start, sample_fall, sel_pos, use_partner, din;
  logic [4:0]    n_edges;
  logic [7:0]    tx_byte;
  uss_pin_t      pa_out, pa_oe, pb_out, pb_oe;
  wire uss_pin_t pa_in, pb_in;
  wire logic     link_clk, dsrc;
  int            failures, check_count, cyc;

  // pin wires: a driven clock pin wins over the partner's clock
  assign dsrc = use_partner ? sdi : din;
  assign pb_in = {pb_oe[2] ? pb_out[2] : (!sel_pos & sck), pb_out[1],
                  !sel_pos & dsrc};
  assign pa_in = {pa_oe[2] ? pa_out[2] : (sel_pos & sck), pa_out[1],
                  sel_pos & dsrc};
  assign link_clk = sel_pos ? pa_in[2] : pb_in[2];

  uss_clock_select u_uss_clock_select (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .link_clk(link_clk), .timer0_match(timer0_match),
    .pa_in(pa_in), .pb_in(pb_in), .pa_out(pa_out), .pa_oe(pa_oe),
    .pb_out(pb_out), .pb_oe(pb_oe)
  );

  uss_serial_partner u_uss_serial_partner (
    .start(start), .n_edges(n_edges), .sample_fall(sample_fall),
    .tx_byte(tx_byte), .sck(sck), .sdi(sdi), .busy(busy)
  );

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  always @(posedge hclk) rdata_q <= hrdata;

  // ---------------------------------------------------------------
  // bus, pin and compare helpers
  // ---------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t ns: read %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_pin(input logic g, input logic e);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t ns: pin %b expected %b", $time, g, e);
    end
  endtask

  task automatic ahb_addr(input logic [31:0] a, input logic w);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= `USS_HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb_addr(a, 1'b1);
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    #1;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    ahb_addr(a, 1'b0);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    #1;
    chk32(rdata_q, e);
  endtask

  task automatic set_pins(input logic pos, input logic up, input logic d);
    @(posedge hclk);
    sel_pos <= pos;
    use_partner <= up;
    din <= d;
  endtask

  // the partner's busy ends a frame; the global timeout bounds it
  task automatic frame(input logic [4:0] n, input logic f,
                       input logic [7:0] b);
    @(posedge hclk);
    n_edges <= n;
    sample_fall <= f;
    tx_byte <= b;
    start <= 1'b1;
    @(posedge hclk);
    start <= 1'b0;
    while (busy) @(posedge hclk);
    repeat (6) @(posedge hclk);
    #1;
  endtask

  task automatic t_reset;
    for (int i = 0; i < 6; i++)
      rd_chk(32'(i * 4), 32'h0000_0000);
    chk_pin(hresp, 1'b0);
    wr(`USS_ADDR_PIN, 32'h0000_00FF);
    rd_chk(`USS_ADDR_PIN, 32'h0000_0001);
    wr(`USS_ADDR_PIN, 32'h0000_0000);
    wr(32'h0000_0020, 32'hFFFF_FFFF);
    rd_chk(32'h0000_0020, 32'h0000_0000);
    $display("reset test done");
  endtask

  task automatic t_strobe;
    set_pins(1'b0, 1'b0, 1'b1);
    wr(`USS_ADDR_PORT, 32'h0000_0004);
    wr(`USS_ADDR_DATA, 32'h0000_00A5);
    wr(`USS_ADDR_CTL, 32'h0000_0010);
    chk_pin(pb_out[1], 1'b1);
    rd_chk(`USS_ADDR_DATA, 32'h0000_00A5);
    wr(`USS_ADDR_CTL, 32'h0000_0012);
    chk_pin(pb_out[1], 1'b0);
    rd_chk(`USS_ADDR_DATA, 32'h0000_004B);
    set_pins(1'b0, 1'b0, 1'b0);
    wr(`USS_ADDR_CTL, 32'h0000_0012);
    chk_pin(pb_out[1], 1'b1);
    rd_chk(`USS_ADDR_DATA, 32'h0000_0096);
    rd_chk(`USS_ADDR_STS, 32'h0000_0002);
    $display("strobe test done");
  endtask

  task automatic t_timer;
    set_pins(1'b0, 1'b0, 1'b1);
    wr(`USS_ADDR_CTL, 32'h0000_0016);
    rd_chk(`USS_ADDR_CTL, 32'h0000_0014);
    rd_chk(`USS_ADDR_STS, 32'h0000_0002);
    @(posedge hclk);
    timer0_match <= 1'b1;
    @(posedge hclk);
    timer0_match <= 1'b0;
    repeat (3) @(posedge hclk);
    #1;
    chk_pin(pb_out[1], 1'b0);
    rd_chk(`USS_ADDR_DATA, 32'h0000_002D);
    rd_chk(`USS_ADDR_STS, 32'h0000_0003);
    $display("timer test done");
  endtask

  task automatic t_toggle;
    wr(`USS_ADDR_PORT, 32'h0000_0000);
    wr(`USS_ADDR_CTL, 32'h0000_0001);
    rd_chk(`USS_ADDR_PORT, 32'h0000_0001);
    chk_pin(pb_oe[2], 1'b0);
    wr(`USS_ADDR_PORT, 32'h0000_0003);
    chk_pin(pb_out[2], 1'b1);
    wr(`USS_ADDR_CTL, 32'h0000_0001);
    chk_pin(pb_out[2], 1'b0);
    rd_chk(`USS_ADDR_PORT, 32'h0000_0002);
    wr(`USS_ADDR_PORT, 32'h0000_0000);
    wr(`USS_ADDR_STS, 32'h0000_0000);
    wr(`USS_ADDR_CTL, 32'h0000_000B);
    wr(`USS_ADDR_CTL, 32'h0000_000B);
    rd_chk(`USS_ADDR_STS, 32'h0000_0002);
    rd_chk(`USS_ADDR_DATA, 32'h0000_002D);
    rd_chk(`USS_ADDR_CTL, 32'h0000_0008);
    $display("toggle test done");
  endtask

  task automatic t_ext;
    set_pins(1'b0, 1'b1, 1'b0);
    wr(`USS_ADDR_STS, 32'h0000_0000);
    wr(`USS_ADDR_PORT, 32'h0000_0001);
    wr(`USS_ADDR_CTL, 32'h0000_0038);
    frame(5'd16, 1'b0, 8'hC3);
    rd_chk(`USS_ADDR_DATA, 32'h0000_00C3);
    rd_chk(`USS_ADDR_STS, 32'h0000_0010);
    wr(`USS_ADDR_PORT, 32'h0000_0003);
    chk_pin(pb_oe[2], 1'b1);
    chk_pin(pb_out[2], 1'b0);
    wr(`USS_ADDR_STS, 32'h0000_0010);
    chk_pin(pb_oe[2], 1'b0);
    wr(`USS_ADDR_PORT, 32'h0000_0000);
    wr(`USS_ADDR_CTL, 32'h0000_000C);
    frame(5'd16, 1'b1, 8'h5A);
    rd_chk(`USS_ADDR_DATA, 32'h0000_005A);
    rd_chk(`USS_ADDR_STS, 32'h0000_0010);
    chk32(32'(pb_oe), 32'h0000_0000);
    $display("external clock test done");
  endtask

  task automatic t_latch;
    wr(`USS_ADDR_PORT, 32'h0000_0004);
    wr(`USS_ADDR_CTL, 32'h0000_0018);
    wr(`USS_ADDR_DATA, 32'h0000_0040);
    frame(5'd2, 1'b0, 8'h00);
    chk_pin(pb_out[1], 1'b1);
    frame(5'd1, 1'b0, 8'h00);
    rd_chk(`USS_ADDR_DATA, 32'h0000_0000);
    chk_pin(pb_out[1], 1'b1);
    frame(5'd1, 1'b0, 8'h00);
    chk_pin(pb_out[1], 1'b0);
    $display("latch test done");
  endtask

  task automatic t_pos;
    wr(`USS_ADDR_PIN, 32'h0000_0001);
    set_pins(1'b1, 1'b0, 1'b1);
    wr(`USS_ADDR_CTL, 32'h0000_0010);
    wr(`USS_ADDR_DATA, 32'h0000_0081);
    chk_pin(pa_out[1], 1'b1);
    chk_pin(pa_oe[1], 1'b1);
    chk32(32'(pb_oe), 32'h0000_0000);
    wr(`USS_ADDR_CTL, 32'h0000_0012);
    chk_pin(pa_out[1], 1'b0);
    rd_chk(`USS_ADDR_DATA, 32'h0000_0003);
    wr(`USS_ADDR_PIN, 32'h0000_0000);
    set_pins(1'b0, 1'b0, 1'b0);
    rd_chk(`USS_ADDR_PIN, 32'h0000_0000);
    $display("pin position test done");
  endtask

  // ---------------------------------------------------------------
  // sequence and hang guard
  // ---------------------------------------------------------------
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      final_report;
    end
  end

  initial
  begin
    {hresetn, hsel, hwrite, timer0_match, start} = 5'h00;
    {haddr, hwdata} = 64'h0;
    {htrans, hsize, n_edges, tx_byte} = 18'h0;
    {sample_fall, sel_pos, use_partner, din} = 4'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_strobe;
    t_timer;
    t_toggle;
    t_ext;
    t_latch;
    t_pos;
    final_report;
  end
endmodule // serial_shift_clock_select_tb
`default_nettype wire
